// ### include/pira_defines.vh
// constants for the process image register access block
`ifndef PIRA_DEFINES_VH
`define PIRA_DEFINES_VH
`define PIRA_CTL_REG_BIT 7
`define PIRA_CTL_WR_BIT 6
`define PIRA_CTL_NUM_MSB 5
`define PIRA_CTL_NUM_LSB 0
`define PIRA_NUM_REVISION 6'h09
`define PIRA_NUM_UNLOCK 6'h1F
`define PIRA_NUM_FEATURE 6'h20
`define PIRA_UNLOCK_CODE 16'h1235
`define PIRA_ZERO_WORD 16'h0000
`define PIRA_ZERO_BYTE 8'h00
`define PIRA_USER_FIRST 6'h20
`define PIRA_USER_COUNT 32
`endif

// ### logic/pira_user_bank.v
// protected user register bank with shadow copy reloaded at soft restart
`timescale 1ns/1ns
`default_nettype none
`include "pira_defines.vh"
module pira_user_bank #(
    parameter COUNT = `PIRA_USER_COUNT,
    parameter [15:0] FEATURE_RESET = 16'h0000
) (
    // clock and reset
    input wire ref_clk_in,
    input wire srst_in,
    // access
    input wire wr_en_in,
    input wire [4:0] idx_in,
    input wire [15:0] wdata_in,
    input wire [4:0] ridx_in,
    output wire [15:0] rdata_out,
    // word in force, first slot is the feature word
    output wire [15:0] active_feature_out
);
    reg [15:0] store_reg [0:COUNT-1];
    reg [15:0] active_reg;
    integer i;
    // stored words survive srst, which stands for a soft restart only
    always @(posedge ref_clk_in) begin
        if (wr_en_in) begin
            store_reg[idx_in] <= wdata_in;
        end
    end
    initial begin
        for (i = 0; i < COUNT; i = i + 1) begin
            store_reg[i] = (i == 0) ? FEATURE_RESET : `PIRA_ZERO_WORD;
        end
    end
    // in-force copy reloads only at restart, not on write
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            active_reg <= store_reg[0];
        end
    end
    assign rdata_out = store_reg[ridx_in];
    assign active_feature_out = active_reg;
endmodule
`default_nettype wire

// ### logic/pira_reg_access.v
// register access through cyclic process data
`timescale 1ns/1ns
`default_nettype none
`include "pira_defines.vh"
module pira_reg_access #(
    parameter [15:0] REVISION = 16'h3030, // arbitrary value
    parameter [15:0] FEATURE_RESET = 16'h0000
) (
    // clock and reset
    input wire ref_clk_in,
    input wire srst_in,
    // host to terminal process image
    input wire [7:0] ctrl_byte_in,
    input wire [7:0] host_to_terminal_hi_in,
    input wire [7:0] host_to_terminal_lo_in,
    // normal process data when register mode is off
    input wire [7:0] proc_status_in,
    input wire [15:0] proc_word_in,
    // terminal to host process image
    output reg [7:0] status_byte_out,
    output reg [7:0] terminal_to_host_hi_out,
    output reg [7:0] terminal_to_host_lo_out,
    // protection and feature word in force
    output reg unlocked_out,
    output reg [15:0] feature_active_out
);
    localparam ST_IDLE = 2'b01;
    localparam ST_DONE = 2'b10;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [15:0] code_reg;
    reg [7:0] last_ctrl_reg;
    wire reg_mode = ctrl_byte_in[`PIRA_CTL_REG_BIT];
    wire is_write = ctrl_byte_in[`PIRA_CTL_WR_BIT];
    wire [5:0] num =
        ctrl_byte_in[`PIRA_CTL_NUM_MSB:`PIRA_CTL_NUM_LSB];
    wire [15:0] wword =
        {host_to_terminal_hi_in, host_to_terminal_lo_in};
    wire unlocked = (code_reg == `PIRA_UNLOCK_CODE);
    wire [15:0] bank_rdata;
    wire [15:0] bank_feature;

    function is_user;
        input [5:0] n;
        begin
            is_user = (n >= `PIRA_USER_FIRST);
        end
    endfunction

    // new request on entering register mode or on a control byte change within it, so a held one runs once
    wire new_req = reg_mode && (state_reg == ST_IDLE ||
        ctrl_byte_in != last_ctrl_reg);
    wire bank_wr = new_req && is_write && is_user(num) &&
        unlocked;

    pira_user_bank #(
        .COUNT(`PIRA_USER_COUNT),
        .FEATURE_RESET(FEATURE_RESET)
    ) u_bank (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .wr_en_in(bank_wr),
        .idx_in(num[4:0]),
        .wdata_in(wword),
        .ridx_in(num[4:0]),
        .rdata_out(bank_rdata),
        .active_feature_out(bank_feature)
    );

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (new_req) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                if (!reg_mode) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            state_reg <= ST_IDLE;
            code_reg <= `PIRA_ZERO_WORD;
            last_ctrl_reg <= `PIRA_ZERO_BYTE;
            status_byte_out <= `PIRA_ZERO_BYTE;
            terminal_to_host_hi_out <= `PIRA_ZERO_BYTE;
            terminal_to_host_lo_out <= `PIRA_ZERO_BYTE;
            unlocked_out <= 1'b0;
            feature_active_out <= FEATURE_RESET;
        end else begin
            state_reg <= state_next;
            last_ctrl_reg <= ctrl_byte_in;
            unlocked_out <= unlocked;
            feature_active_out <= bank_feature;
            if (!reg_mode) begin
                status_byte_out <= proc_status_in;
                terminal_to_host_hi_out <= proc_word_in[15:8];
                terminal_to_host_lo_out <= proc_word_in[7:0];
            end else if (new_req && is_write) begin
                // register 31 always writable; value decides lock
                if (num == `PIRA_NUM_UNLOCK) begin
                    code_reg <= wword;
                end
                // word left stale, host must discard it
                status_byte_out <= {ctrl_byte_in[7],
                    1'b0, ctrl_byte_in[5:0]};
            end else if (new_req) begin
                status_byte_out <= ctrl_byte_in;
                if (num == `PIRA_NUM_REVISION) begin
                    terminal_to_host_hi_out <= REVISION[15:8];
                    terminal_to_host_lo_out <= REVISION[7:0];
                end else if (num == `PIRA_NUM_UNLOCK) begin
                    terminal_to_host_hi_out <= code_reg[15:8];
                    terminal_to_host_lo_out <= code_reg[7:0];
                end else if (is_user(num)) begin
                    terminal_to_host_hi_out <= bank_rdata[15:8];
                    terminal_to_host_lo_out <= bank_rdata[7:0];
                end else begin
                    terminal_to_host_hi_out <= `PIRA_ZERO_BYTE;
                    terminal_to_host_lo_out <= `PIRA_ZERO_BYTE;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/pira_props.sv
// assertions on the register access ports
`timescale 1ns/1ns
`default_nettype none
module pira_props #(
    parameter [15:0] REVISION = 16'h3030
) (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic [7:0] ctrl_byte_in,
    input wire logic [7:0] host_to_terminal_hi_in,
    input wire logic [7:0] host_to_terminal_lo_in,
    input wire logic [7:0] status_byte_out,
    input wire logic [7:0] terminal_to_host_hi_out,
    input wire logic [7:0] terminal_to_host_lo_out,
    input wire logic unlocked_out,
    input wire logic [15:0] feature_active_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    wire [7:0] c = ctrl_byte_in;
    wire [15:0] wi = {host_to_terminal_hi_in, host_to_terminal_lo_in};
    wire [15:0] wo = {terminal_to_host_hi_out, terminal_to_host_lo_out};
    sequence s_new;
        c[7] && c != $past(c);
    endsequence
    property p_rd_ack;
        s_new ##0 !c[6] |=> status_byte_out == $past(c);
    endproperty
    a_rd_ack: assert property (p_rd_ack) else $error("read echo");
    property p_wr_ack;
        s_new ##0 c[6] |=> status_byte_out == ($past(c) & 8'hBF);
    endproperty
    a_wr_ack: assert property (p_wr_ack) else $error("write echo");
    property p_rev;
        s_new ##0 c == 8'h89 |=> wo == REVISION;
    endproperty
    a_rev: assert property (p_rev) else $error("revision");
    property p_code_rd;
        s_new ##0 c == 8'h9F |=> unlocked_out == (wo == 16'h1235);
    endproperty
    a_code_rd: assert property (p_code_rd) else $error("code read");
    property p_unlock;
        s_new ##0 c == 8'hDF && wi == 16'h1235 |-> ##[1:2] unlocked_out;
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock");
    property p_relock;
        s_new ##0 c == 8'hDF && wi != 16'h1235 |-> ##[1:2] !unlocked_out;
    endproperty
    a_relock: assert property (p_relock) else $error("relock");
    // previous cycle idle so a late unlock cannot land here
    property p_prot;
        !unlocked_out && !$past(c[7]) && c[7:6] == 2'b11
            && c[5:0] != 6'h1F |=> !unlocked_out;
    endproperty
    a_prot: assert property (p_prot) else $error("protect");
    property p_feat;
        !$past(srst_in) && !$past(srst_in, 2) |-> $stable(feature_active_out);
    endproperty
    a_feat: assert property (p_feat) else $error("feature");
    c_wr: cover property (s_new ##0 c == 8'hE0);
    c_rd: cover property (s_new ##0 c == 8'h9F);
    c_un: cover property (unlocked_out);
endmodule
`default_nettype wire

// ### tb/pira_host_model.sv
// host side model driving the process image
`timescale 1ns/1ns
`default_nettype none
module pira_host_model (
    input wire logic ref_clk_in,
    output logic [7:0] ctrl_byte_out,
    output logic [7:0] hi_out,
    output logic [7:0] lo_out
);
    initial begin
        ctrl_byte_out = 8'h00;
        hi_out = 8'hA5;
        lo_out = 8'h5A;
    end
    // held until the answer stands
    task automatic req(input logic [7:0] c, input logic [15:0] w);
        ctrl_byte_out = c;
        hi_out = w[15:8];
        lo_out = w[7:0];
        repeat (2) @(posedge ref_clk_in);
        #1;
    endtask
    // drop register mode so a repeat counts as new; word released
    task automatic idle;
        ctrl_byte_out = 8'h00;
        hi_out = ~hi_out;
        lo_out = ~lo_out;
        @(posedge ref_clk_in);
        #1;
    endtask
endmodule
`default_nettype wire

// ### tb/pira_reg_access_tb_top.sv
// testbench for the register access block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
    $display("unexpected %0t %h %h", $time, (a), (b)); end end
module pira_reg_access_tb_top;
    localparam [15:0] REV = 16'h4142; // arbitrary value
    logic ref_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [7:0] ctrl, hi, lo, st, oh, ol;
    logic unl;
    logic [15:0] feat, f0;
    int num_errors = 0;
    int cmp_count = 0;
    initial forever #10 ref_clk_in = ~ref_clk_in;
    pira_host_model host (.ref_clk_in, .ctrl_byte_out(ctrl), .hi_out(hi),
        .lo_out(lo));
    pira_reg_access #(.REVISION(REV)) uut (.ref_clk_in, .srst_in,
        .ctrl_byte_in(ctrl), .host_to_terminal_hi_in(hi),
        .host_to_terminal_lo_in(lo), .proc_status_in(8'h3C),
        .proc_word_in(16'hC3C3), .status_byte_out(st),
        .terminal_to_host_hi_out(oh), .terminal_to_host_lo_out(ol),
        .unlocked_out(unl), .feature_active_out(feat));
    // word not compared after writes, it is stale there
    task automatic xfer(input logic [7:0] c, input logic [15:0] w,
        input logic [7:0] es, input logic [15:0] ew);
        host.req(c, w);
        `CHK(st, es)
        if (!c[6]) `CHK({oh, ol}, ew)
        host.idle;
        `CHK(st, 8'h3C)
        `CHK({oh, ol}, 16'hC3C3)
    endtask
    task automatic end_sim;
        if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge ref_clk_in);
        #1 srst_in = 1'b0;
        f0 = feat;
        xfer(8'h89, 16'hFFFF, 8'h89, REV);
        xfer(8'hDF, 16'h1235, 8'h9F, 16'h0000);
        `CHK(unl, 1'b1)
        xfer(8'h9F, 16'h5A5A, 8'h9F, 16'h1235);
        xfer(8'hE0, 16'h0002, 8'hA0, 16'h0000);
        xfer(8'hA0, 16'hFFFF, 8'hA0, 16'h0002);
        `CHK(feat, f0)
        xfer(8'hDF, 16'h0000, 8'h9F, 16'h0000);
        `CHK(unl, 1'b0)
        xfer(8'hE0, 16'h00FF, 8'hA0, 16'h0000);
        xfer(8'hA0, 16'h0000, 8'hA0, 16'h0002);
        xfer(8'h9F, 16'h0000, 8'h9F, 16'h0000);
        srst_in = 1'b1;
        repeat (4) @(posedge ref_clk_in);
        #1 srst_in = 1'b0;
        // in-force copy reaches the port one edge after release
        @(posedge ref_clk_in);
        #1;
        `CHK(feat, 16'h0002)
        end_sim;
    end
endmodule
bind pira_reg_access pira_props #(.REVISION(REVISION)) u_props (
    .ref_clk_in, .srst_in, .ctrl_byte_in, .host_to_terminal_hi_in,
    .host_to_terminal_lo_in, .status_byte_out, .terminal_to_host_hi_out,
    .terminal_to_host_lo_out, .unlocked_out, .feature_active_out);
`default_nettype wire
